// >>> bench/snc_host.sv
`include "snc_map.svh"
module snc_host (
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_miso_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Serial host, mode 0, clock still between frames
    // ****************************************
    localparam time HALF = 40;
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // Opcode then nb bytes; a second config byte is sent whole
    task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nb,
                         output logic [15:0] rd);
        logic [23:0] sh;
        sh = {op, wd};
        rd = 16'h0000;
        o_cs_n <= 1'b0;
        #HALF;
        for (int i = 0; i < 8 + 8 * nb; i++) begin
            o_mosi <= sh[23];
            sh = sh << 1;
            #HALF;
            o_sclk <= 1'b1;
            if (i >= 8) rd = {rd[14:0], i_miso_oe ? i_miso : 1'bx};
            #HALF;
            o_sclk <= 1'b0;
        end
        #HALF;
        o_cs_n <= 1'b1;
        // Released line flips so a stale level cannot pass for data
        o_mosi <= ~o_mosi;
        #(4 * HALF);
    endtask : frame
    // Only status reads go out until the write cycle ends
    task automatic poll(output logic ok);
        logic [15:0] r;
        ok = 1'b0;
        for (int n = 0; n < 100 && !ok; n++) begin
            frame(`SNC_OP_RD_SR1, 16'h0000, 1, r);
            ok = (r[0] === 1'b0);
        end
    endtask : poll
    // Read, change masked bits only, write back, wait, read again
    task automatic rmw_cfg(input logic [7:0] mask, input logic [7:0] val,
                           output logic [15:0] rb);
        logic [15:0] cur;
        logic ok;
        frame(`SNC_OP_RD_CFG, 16'h0000, 2, cur);
        frame(`SNC_OP_WR_CFG, {(cur[15:8] & ~mask) | (val & mask), cur[7:0]}, 2, rb);
        poll(ok);
        frame(`SNC_OP_RD_CFG, 16'h0000, 2, rb);
    endtask : rmw_cfg
endmodule : snc_host

// >>> bench/tb_top.sv
`include "snc_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 2000;
    typedef struct packed {
        logic [7:0] op, b1, b2;
        logic dual;
        logic [7:0] e1, e2, es;
    } snc_row_s;
    snc_row_s rows [6] = '{
        '{8'h31, 8'hFF, 8'hFF, 1'b0, 8'hDF, 8'h00, 8'h00},
        '{8'h31, 8'h00, 8'h02, 1'b1, 8'h08, 8'h02, 8'h00},
        '{8'h31, 8'h50, 8'h00, 1'b1, 8'h58, 8'h00, 8'h00},
        '{8'h01, 8'hFF, 8'h00, 1'b1, 8'h58, 8'h00, 8'hFC},
        '{8'h01, 8'h97, 8'h00, 1'b1, 8'h58, 8'h00, 8'h94},
        '{8'h31, 8'hA5, 8'hFF, 1'b1, 8'h8D, 8'h02, 8'h94}};
    logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, ok;
    logic awready, wready, bvalid, arready, rvalid, sclk, cs_n, mosi, miso, miso_oe, busy;
    logic [7:0] awaddr, araddr, cfg1, cfg2, sr1;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] rd;
    int n_errors = 0;
    int compares = 0;
    int n;
    snc_regs #(.WR_CYCLE_CYC(WC)) DUT (.i_clk_sys(clk), .i_arst_n(arst_n),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_wdata(wdata), .i_axi_wstrb(4'hF), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_link_sclk(sclk), .i_link_cs_n(cs_n), .i_link_mosi(mosi), .o_link_miso(miso),
        .o_link_miso_oe(miso_oe), .o_config_primary(cfg1), .o_config_secondary(cfg2),
        .o_protection_status_one(sr1), .o_busy(busy));
    snc_host h (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe(miso_oe));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        r = 2'b11;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int k = 0; k < 100 && !(aw_ok && w_ok); k++) begin
            @(negedge clk);
            aw_ok = aw_ok | (awvalid & awready);
            w_ok = w_ok | (wvalid & wready);
            @(posedge clk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        for (int k = 0; k < 100 && r === 2'b11; k++) begin
            @(negedge clk);
            if (bvalid === 1'b1) r = bresp;
            @(posedge clk);
        end
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic got, tk;
        got = 1'b0;
        r = 2'b11;
        v = 'x;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int k = 0; k < 100 && !got; k++) begin
            @(negedge clk);
            got = (rvalid === 1'b1);
            if (got) begin
                v = rdata;
                r = rresp;
            end
            tk = arvalid & arready;
            @(posedge clk);
            if (tk) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_rd
    task automatic busy_len(output int m);
        m = 0;
        for (int k = 0; k < 1000 && busy !== 1'b1; k++) @(negedge clk);
        while (busy === 1'b1 && m < 5 * WC) begin
            @(negedge clk);
            m++;
        end
    endtask : busy_len
    task automatic end_sim;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #400us;
        n_errors++;
        end_sim();
    end
    initial begin
        {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk({cfg1, cfg2, sr1, busy, miso_oe}, 26'h0);
        axi_rd(`SNC_A_CTRL, d, rs);
        chk(d, 32'h0);
        foreach (rows[i]) begin
            axi_wr(`SNC_A_CTRL, {31'h0, rows[i].dual}, rs);
            chk(rs, `SNC_RESP_OK);
            // Busy is timed alongside the frame so its start is not missed
            fork
                h.frame(rows[i].op, {rows[i].b1, rows[i].b2}, (rows[i].op == 8'h31) ? 2 : 1, rd);
                busy_len(n);
            join
            chk(n >= WC && n <= WC + 1, 1);
            chk({cfg1, cfg2, sr1}, {rows[i].e1, rows[i].e2, rows[i].es});
            h.frame(`SNC_OP_RD_CFG, 16'h0, 2, rd);
            chk(rd, {rows[i].e1, rows[i].e2});
            h.frame(`SNC_OP_RD_SR1, 16'h0, 1, rd);
            chk(rd, {8'h0, rows[i].es});
            axi_rd(`SNC_A_SR1, d, rs);
            chk(d, {24'h0, rows[i].es});
        end
        h.frame(`SNC_OP_EN4B, 16'h0, 0, rd);
        repeat (20) @(posedge clk);
        chk({cfg1, busy}, {8'hAD, 1'b0});
        h.rmw_cfg(8'h20, 8'h00, rd);
        chk(rd, 16'hAD02);
        h.frame(`SNC_OP_WR_SR1, 16'h0, 1, rd);
        h.frame(`SNC_OP_WR_CFG, 16'h0, 2, rd);
        h.frame(`SNC_OP_RD_CFG, 16'h0, 2, rd);
        chk(rd, 16'h0);
        axi_rd(`SNC_A_STAT, d, rs);
        chk(d[15:0], 16'h0201);
        h.poll(ok);
        chk({ok, sr1, cfg1}, {1'b1, 8'h00, 8'hAD});
        axi_wr(8'h10, 32'hFF, rs);
        chk(rs, `SNC_RESP_ERR);
        axi_rd(8'h10, d, rs);
        chk({rs, d}, {`SNC_RESP_ERR, 32'h0});
        axi_wr(`SNC_A_CFG, 32'hFFFF, rs);
        chk({rs, cfg1, cfg2}, {`SNC_RESP_OK, 8'hAD, 8'h02});
        end_sim();
    end
endmodule : tb_top

// >>> core/snc_map.svh
`ifndef SNC_MAP_SVH
`define SNC_MAP_SVH
// ****************************************
// Config register one field positions
// ****************************************
`define SNC_CFG1_DC_HI 7
`define SNC_CFG1_DC_LO 6
`define SNC_CFG1_ADDR 5
`define SNC_CFG1_PRE 4
`define SNC_CFG1_TB 3
`define SNC_CFG1_ODS_HI 2
`define SNC_CFG1_ODS_LO 0
`define SNC_CFG1_WMASK 8'hDF
`define SNC_CFG1_OTP 8'h08
// ****************************************
// Config register two and status one, then reset values of all three
// ****************************************
`define SNC_CFG2_LH 1
`define SNC_CFG2_MASK 8'h02
`define SNC_SR1_SRP 7
`define SNC_SR1_BP 6
`define SNC_SR1_TB 5
`define SNC_SR1_BPL_HI 4
`define SNC_SR1_BPL_LO 2
`define SNC_SR1_BUSY 0
`define SNC_SR1_MASK 8'hFC
`define SNC_CFG1_RST 8'h00
`define SNC_CFG2_RST 8'h00
`define SNC_SR1_RST 8'h00
// ****************************************
// Link opcodes
// ****************************************
`define SNC_OP_WR_SR1 8'h01
`define SNC_OP_RD_SR1 8'h05
`define SNC_OP_WR_CFG 8'h31
`define SNC_OP_RD_CFG 8'h15
`define SNC_OP_EN4B 8'hB7
`define SNC_IDX_MAX 2'h3
// ****************************************
// Register bus map
// ****************************************
`define SNC_A_CTRL 8'h00
`define SNC_A_STAT 8'h04
`define SNC_A_CFG 8'h08
`define SNC_A_SR1 8'h0C
`define SNC_CTRL_DUAL 0
`define SNC_STAT_BUSY 0
`define SNC_STAT_REF_LO 8
`define SNC_CFG_C2_LO 8
`define SNC_RESP_OK 2'b00
`define SNC_RESP_ERR 2'b10
`endif

// >>> core/snc_pkg.sv
package snc_pkg;
    typedef enum logic {SNC_WC_IDLE, SNC_WC_BUSY} snc_wc_e;
    typedef enum logic [1:0] {SNC_TGT_NONE, SNC_TGT_SR1, SNC_TGT_CFG} snc_tgt_e;
endpackage : snc_pkg

// >>> core/snc_regs.sv
// Notes on behaviour
// - Config register one bit 5 shows address width, 1 for four bytes, 0 for three.
// - A config write leaves the address width bit alone; only the enter-four-byte op sets it.
// - Config register one bit 4 enables the preamble pattern when 1.
// - Config register one bit 3 selects bottom area protection when 1, top when 0.
// - Bits 7..6 hold the dummy cycle count and bits 2..0 the output drive strength.
// - Config register two bit 1 selects high performance when 1; its other bits are reserved.
// - With two config registers the two written bytes load them in turn; else byte two is dropped.
// - An accepted config or status write starts a self-timed internal write cycle.
// - While a write cycle runs new config reads and writes are refused; status one reads are answered, and the host polls them for the end.
// - Status one holds protect bit 0 at 7, block protect at 6, top/bottom at 5, level at 4..2.
`include "snc_map.svh"
module snc_regs import snc_pkg::*; #(
    parameter int WR_CYCLE_CYC = 64
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [7:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [7:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    input wire logic i_link_sclk,
    input wire logic i_link_cs_n,
    input wire logic i_link_mosi,
    output logic o_link_miso,
    output logic o_link_miso_oe,
    output logic [7:0] o_config_primary,
    output logic [7:0] o_config_secondary,
    output logic [7:0] o_protection_status_one,
    output logic o_busy
);
    localparam int CW = $clog2(WR_CYCLE_CYC);

    if (WR_CYCLE_CYC < 2) begin : g_bad_len
        $error("WR_CYCLE_CYC must be at least 2");
    end

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    logic [7:0] cfg1_reg, cfg2_reg, sr1_reg;
    snc_wc_e wc_reg;
    wire busy = (wc_reg == SNC_WC_BUSY);

    // ****************************************
    // Link side, runs on the host clock
    // ****************************************
    // Frame state clears on chip select so a stopped clock never strands it
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [1:0] idx_reg;
    logic [7:0] op_reg, hold_byte_reg, tx_sh_reg;
    logic [1:0] hold_idx_reg;
    logic byte_tgl_reg, miso_oe_reg;
    logic [24:0] view_s1_reg, view_reg;
    wire [7:0] rx_byte = {rx_sh_reg, i_link_mosi};
    wire byte_done = (bit_cnt_reg == 3'h7);

    always_ff @(posedge i_link_sclk or posedge i_link_cs_n) begin
        if (i_link_cs_n) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
            idx_reg <= 2'h0;
            op_reg <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg <= {rx_sh_reg[5:0], i_link_mosi};
            if (byte_done && idx_reg == 2'h0) op_reg <= rx_byte;
            if (byte_done && idx_reg != `SNC_IDX_MAX) idx_reg <= idx_reg + 2'h1;
        end
    end

    // Byte and index are held past the frame so the slow side reads them stable
    always_ff @(posedge i_link_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hold_byte_reg <= 8'h00;
            hold_idx_reg <= 2'h0;
            byte_tgl_reg <= 1'b0;
            view_s1_reg <= 25'h0;
            view_reg <= 25'h0;
        end else begin
            if (!i_link_cs_n && byte_done) begin
                hold_byte_reg <= rx_byte;
                hold_idx_reg <= idx_reg;
                byte_tgl_reg <= ~byte_tgl_reg;
            end
            // Registers change together with busy falling, or for the address bit alone on enter-four-byte, so the copy stays coherent
            view_s1_reg <= {busy, cfg2_reg, cfg1_reg, sr1_reg};
            view_reg <= view_s1_reg;
        end
    end

    wire view_busy = view_reg[24];
    wire rd_sr = (op_reg == `SNC_OP_RD_SR1);
    wire rd_cfg = (op_reg == `SNC_OP_RD_CFG);
    wire [7:0] sr_view = {view_reg[7:1], view_busy};
    wire [7:0] cfg_view = (idx_reg == 2'h1) ? view_reg[15:8] : view_reg[23:16];
    wire [7:0] tx_byte = rd_sr ? sr_view : (rd_cfg && !view_busy) ? cfg_view : 8'h00;

    always_ff @(negedge i_link_sclk or posedge i_link_cs_n) begin
        if (i_link_cs_n) begin
            tx_sh_reg <= 8'h00;
            miso_oe_reg <= 1'b0;
        end else if (bit_cnt_reg == 3'h0 && idx_reg != 2'h0) begin
            tx_sh_reg <= tx_byte;
            miso_oe_reg <= rd_sr | rd_cfg;
        end else begin
            tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
    end

    // ****************************************
    // Crossing into the system clock
    // ****************************************
    logic tgl_s1_reg, tgl_s2_reg, tgl_d_reg, cs_s1_reg, cs_s2_reg, cs_d_reg;
    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            tgl_s1_reg <= 1'b0;
            tgl_s2_reg <= 1'b0;
            tgl_d_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_d_reg <= 1'b1;
        end else begin
            tgl_s1_reg <= byte_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_d_reg <= tgl_s2_reg;
            cs_s1_reg <= i_link_cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_d_reg <= cs_s2_reg;
        end
    end
    wire byte_ev = tgl_s2_reg ^ tgl_d_reg;
    wire frame_end = cs_s2_reg & ~cs_d_reg;

    // ****************************************
    // Command decode and write cycle
    // ****************************************
    logic [7:0] f_op_reg, f_b1_reg, f_b2_reg;
    logic [1:0] f_cnt_reg;
    logic [7:0] pend_sr1_reg, pend_cfg1_reg, pend_cfg2_reg;
    logic pend_two_reg, dual_reg;
    snc_tgt_e tgt_reg;
    logic [CW-1:0] cnt_reg;
    logic [7:0] ref_cnt_reg;

    wire is_wr_sr = (f_op_reg == `SNC_OP_WR_SR1) && (f_cnt_reg != 2'h0);
    wire is_wr_cfg = (f_op_reg == `SNC_OP_WR_CFG) && (f_cnt_reg != 2'h0);
    wire is_en4b = (f_op_reg == `SNC_OP_EN4B);
    wire is_rd_cfg = (f_op_reg == `SNC_OP_RD_CFG);
    wire start_wr = frame_end && !busy && (is_wr_sr || is_wr_cfg);
    wire en4b_go = frame_end && !busy && is_en4b;
    wire refused = frame_end && busy && (is_wr_sr || is_wr_cfg || is_en4b || is_rd_cfg);
    wire cycle_done = busy && (cnt_reg == CW'(WR_CYCLE_CYC - 1));
    wire take_two = dual_reg && (f_cnt_reg == 2'h2);
    // Address width stays, the one-time protect select can only be raised
    wire [7:0] cfg1_next = (pend_cfg1_reg & `SNC_CFG1_WMASK) |
        (cfg1_reg & (~`SNC_CFG1_WMASK | `SNC_CFG1_OTP));

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            f_op_reg <= 8'h00;
            f_b1_reg <= 8'h00;
            f_b2_reg <= 8'h00;
            f_cnt_reg <= 2'h0;
        end else if (frame_end) begin
            f_op_reg <= 8'h00;
            f_cnt_reg <= 2'h0;
        end else if (byte_ev) begin
            if (hold_idx_reg == 2'h0) f_op_reg <= hold_byte_reg;
            if (hold_idx_reg == 2'h1) f_b1_reg <= hold_byte_reg;
            if (hold_idx_reg == 2'h2) f_b2_reg <= hold_byte_reg;
            if (hold_idx_reg != 2'h0 && f_cnt_reg != 2'h2) f_cnt_reg <= f_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pend_sr1_reg <= 8'h00;
            pend_cfg1_reg <= 8'h00;
            pend_cfg2_reg <= 8'h00;
            pend_two_reg <= 1'b0;
            tgt_reg <= SNC_TGT_NONE;
        end else if (start_wr) begin
            pend_sr1_reg <= f_b1_reg;
            pend_cfg1_reg <= f_b1_reg;
            pend_cfg2_reg <= f_b2_reg;
            pend_two_reg <= is_wr_cfg && take_two;
            tgt_reg <= is_wr_sr ? SNC_TGT_SR1 : SNC_TGT_CFG;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wc_reg <= SNC_WC_IDLE;
            cnt_reg <= '0;
        end else begin
            case (wc_reg)
                SNC_WC_IDLE: begin
                    cnt_reg <= '0;
                    if (start_wr) wc_reg <= SNC_WC_BUSY;
                end
                SNC_WC_BUSY: begin
                    cnt_reg <= cnt_reg + CW'(1);
                    if (cycle_done) wc_reg <= SNC_WC_IDLE;
                end
                default: wc_reg <= SNC_WC_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cfg1_reg <= `SNC_CFG1_RST;
            cfg2_reg <= `SNC_CFG2_RST;
            sr1_reg <= `SNC_SR1_RST;
        end else begin
            if (cycle_done && tgt_reg == SNC_TGT_SR1) sr1_reg <= pend_sr1_reg & `SNC_SR1_MASK;
            if (cycle_done && tgt_reg == SNC_TGT_CFG) cfg1_reg <= cfg1_next;
            if (cycle_done && pend_two_reg) cfg2_reg <= pend_cfg2_reg & `SNC_CFG2_MASK;
            if (en4b_go) cfg1_reg[`SNC_CFG1_ADDR] <= 1'b1;
        end
    end

    // ****************************************
    // Register bus slave
    // ****************************************
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    wire do_wr = !awready_reg && !wready_reg && !bvalid_reg;
    wire wr_hit = (aw_addr_reg == `SNC_A_CTRL) || (aw_addr_reg == `SNC_A_STAT) ||
        (aw_addr_reg == `SNC_A_CFG) || (aw_addr_reg == `SNC_A_SR1);
    wire rd_hit = (i_axi_araddr == `SNC_A_CTRL) || (i_axi_araddr == `SNC_A_STAT) ||
        (i_axi_araddr == `SNC_A_CFG) || (i_axi_araddr == `SNC_A_SR1);
    wire [31:0] rd_ctrl = 32'(dual_reg) << `SNC_CTRL_DUAL;
    wire [31:0] rd_stat = (32'(ref_cnt_reg) << `SNC_STAT_REF_LO) | (32'(busy) << `SNC_STAT_BUSY);
    wire [31:0] rd_cfg_w = (32'(cfg2_reg) << `SNC_CFG_C2_LO) | 32'(cfg1_reg);
    wire [31:0] rd_sr1 = 32'({sr1_reg[7:1], busy});
    wire [31:0] rd_mux = (i_axi_araddr == `SNC_A_CTRL) ? rd_ctrl :
        (i_axi_araddr == `SNC_A_STAT) ? rd_stat :
        (i_axi_araddr == `SNC_A_CFG) ? rd_cfg_w :
        (i_axi_araddr == `SNC_A_SR1) ? rd_sr1 : 32'h0000_0000;

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            // Ready out of reset, so an idle bus never looks like a finished write
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SNC_RESP_OK;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            dual_reg <= 1'b0;
        end else begin
            if (awready_reg && i_axi_awvalid) begin
                awready_reg <= 1'b0;
                aw_addr_reg <= i_axi_awaddr;
            end
            if (wready_reg && i_axi_wvalid) begin
                wready_reg <= 1'b0;
                w_data_reg <= i_axi_wdata;
                w_strb_reg <= i_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `SNC_RESP_OK : `SNC_RESP_ERR;
                if (aw_addr_reg == `SNC_A_CTRL && w_strb_reg[0]) begin
                    dual_reg <= w_data_reg[`SNC_CTRL_DUAL];
                end
            end
            // Ready is loaded by reset and rises again after each answer is taken
            if ((bvalid_reg && i_axi_bready) || (!bvalid_reg && awready_reg == wready_reg &&
                    !do_wr && !awready_reg)) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SNC_RESP_OK;
            ref_cnt_reg <= 8'h00;
        end else begin
            if (arready_reg && i_axi_arvalid) begin
                arready_reg <= 1'b0;
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? `SNC_RESP_OK : `SNC_RESP_ERR;
            end else if (rvalid_reg && i_axi_rready) begin
                rvalid_reg <= 1'b0;
                arready_reg <= 1'b1;
            end
            if (refused && ref_cnt_reg != 8'hFF) ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
    end

    assign o_axi_awready = awready_reg;
    assign o_axi_wready = wready_reg;
    assign o_axi_bvalid = bvalid_reg;
    assign o_axi_bresp = bresp_reg;
    assign o_axi_arready = arready_reg;
    assign o_axi_rvalid = rvalid_reg;
    assign o_axi_rdata = rdata_reg;
    assign o_axi_rresp = rresp_reg;
    assign o_link_miso = tx_sh_reg[7];
    assign o_link_miso_oe = miso_oe_reg;
    assign o_config_primary = cfg1_reg;
    assign o_config_secondary = cfg2_reg;
    assign o_protection_status_one = sr1_reg;
    assign o_busy = wc_reg;

    // ****************************************
    // Checks
    // ****************************************
    addr_only_en4b_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        $rose(cfg1_reg[`SNC_CFG1_ADDR]) |-> $past(en4b_go)) else $error("addr bit set by write");
    cfg_fields_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        cycle_done && tgt_reg == SNC_TGT_CFG |=> cfg1_reg[7:6] == $past(pend_cfg1_reg[7:6]) &&
        cfg1_reg[`SNC_CFG1_PRE] == $past(pend_cfg1_reg[`SNC_CFG1_PRE]) &&
        cfg1_reg[2:0] == $past(pend_cfg1_reg[2:0])) else $error("config fields not loaded");
    start_busy_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        start_wr |=> busy [*2]) else $error("write cycle did not start");
    busy_len_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        $fell(busy) |-> $past(cnt_reg) == CW'(WR_CYCLE_CYC - 1)) else $error("busy length wrong");
    refuse_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        frame_end && busy |=> $stable(pend_cfg1_reg) && $stable(tgt_reg))
        else $error("write taken while busy");
    single_cfg_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        !dual_reg && !busy && start_wr |-> ##1 !pend_two_reg) else $error("byte two used");
    cfg2_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        (cfg2_reg & ~`SNC_CFG2_MASK) == 8'h00) else $error("reserved cfg2 bits set");
    sr1_load_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        cycle_done && tgt_reg == SNC_TGT_SR1 |=> sr1_reg[7:2] == $past(pend_sr1_reg[7:2]))
        else $error("status one not loaded");
    tb_otp_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_reg)
        $past(cfg1_reg[`SNC_CFG1_TB]) |-> cfg1_reg[`SNC_CFG1_TB]) else $error("area select cleared");
endmodule : snc_regs
